// >>> src/sfe_pkg.sv
// Constants, register map and field layout of the front end config bank
// Function
// - Black window horizontal start, bits 12:0
// - Black window vertical start, bits 12:0
// - Black window valid line count, 13 bits
// - Formatter skips pixels before start pixel
// - Formatter accepts pixel count plus one
// - Formatter processes line count plus one
// - Output line length; software keeps <=4480
// - Output lines spaced by sync interval
// - Colour converter on when bit0 set
package sfe_pkg;
   // ****************************************************
   // Bus and map geometry
   // ****************************************************
   localparam int SFE_ADDR_W = 12; // Decoded address bits
   localparam int SFE_IDX_W = 4; // Word index bits
   localparam int SFE_IDX_LSB = 2; // Word aligned index
   localparam int SFE_NCFG = 10; // Writable registers
   localparam logic [2:0] SFE_HSIZE_WORD = 3'h2; // 32-bit size
   localparam int SFE_HTRANS_ACT = 1; // Nonseq/seq bit
   localparam logic SFE_HRESP_OKAY = 1'h0; // Okay answer
   localparam logic [31:0] SFE_RST = 32'h0000_0000; // All reset
   // ****************************************************
   // Register word indices, byte address is index times 4
   // ****************************************************
   localparam logic [3:0] SFE_IDX_OBH = 4'h0; // ob start h
   localparam logic [3:0] SFE_IDX_OBV = 4'h1; // ob start v
   localparam logic [3:0] SFE_IDX_OBN = 4'h2; // ob valid lines
   localparam logic [3:0] SFE_IDX_SPH = 4'h3; // first pixel
   localparam logic [3:0] SFE_IDX_LNH = 4'h4; // pixels - 1
   localparam logic [3:0] SFE_IDX_SLV = 4'h5; // first line
   localparam logic [3:0] SFE_IDX_LNV = 4'h6; // lines - 1
   localparam logic [3:0] SFE_IDX_RLEN = 4'h7; // out length
   localparam logic [3:0] SFE_IDX_HCNT = 4'h8; // sync interval
   localparam logic [3:0] SFE_IDX_CSC = 4'h9; // converter ctl
   localparam logic [3:0] SFE_IDX_STAT = 4'ha; // status, RO
   // ****************************************************
   // Field widths and write masks
   // ****************************************************
   localparam int SFE_W13 = 13; // Most fields
   localparam int SFE_W15 = 15; // Line count field
   localparam logic [31:0] SFE_M13 = 32'h0000_1fff;
   localparam logic [31:0] SFE_M15 = 32'h0000_7fff;
   localparam logic [31:0] SFE_M1 = 32'h0000_0001;
   localparam logic [31:0] SFE_MASK [SFE_NCFG] = '{
      SFE_M13, SFE_M13, SFE_M13, SFE_M13, SFE_M13,
      SFE_M13, SFE_M15, SFE_M13, SFE_M13, SFE_M1};
   localparam int SFE_CSC_ON_BIT = 0; // Converter enable
   // ****************************************************
   // Status word layout
   // ****************************************************
   localparam int SFE_ST_INV_BIT = 0; // Inside line window
   localparam int SFE_ST_SEEN_BIT = 1; // A line has started
   localparam int SFE_ST_LINE_LSB = 16; // Current line index
   localparam int SFE_DEF_PIX_W = 12; // Pixel data width
endpackage

// >>> src/sfe_regs.sv
// Front end config bank on AHB-Lite with formatter cropping
//
// The AHB-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps
module sfe_regs #(
   parameter int PIX_W = sfe_pkg::SFE_DEF_PIX_W
) (
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [sfe_pkg::SFE_ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Sensor side
   input wire logic pix_valid,
   input wire logic [PIX_W-1:0] pix_data,
   input wire logic horizontal_sync,
   input wire logic frame_start,
   // Formatter side
   output logic fmt_pix_valid,
   output logic [PIX_W-1:0] fmt_pix_data,
   output logic fmt_line_end,
   output logic fmt_out_sync,
   // Clamp and converter controls
   output logic [sfe_pkg::SFE_W13-1:0] ob_window_start_h,
   output logic [sfe_pkg::SFE_W13-1:0] ob_window_start_v,
   output logic [sfe_pkg::SFE_W13-1:0] ob_window_valid_v,
   output logic color_convert_on
);
   // ****************************************************
   // Elaboration checks
   // ****************************************************
   generate
      if (PIX_W < 1 || PIX_W > 32)
      begin : g_chk
         $error("sfe_regs: PIX_W out of range");
      end
   endgenerate

   // ****************************************************
   // Declarations
   // ****************************************************
   localparam int IW = sfe_pkg::SFE_IDX_W;
   localparam int W13 = sfe_pkg::SFE_W13;
   localparam int W15 = sfe_pkg::SFE_W15;
   localparam int NC = sfe_pkg::SFE_NCFG;

   // Status word must sit above the config words and hold
   // the whole line index, or reads would alias
   generate
      if (int'(sfe_pkg::SFE_IDX_STAT) < NC ||
         sfe_pkg::SFE_ST_LINE_LSB + W15 > 32)
      begin : g_map_chk
         $error("sfe_regs: register map does not fit");
      end
   endgenerate

   logic [31:0] cfg_r [NC]; // Config words
   logic [NC-1:0] wr_hit; // Per-register write strobe
   logic wr_pend_r; // Write data phase pending
   logic [IW-1:0] wr_idx_r; // Index of pending write
   logic hready_r; // Ready answer
   logic [31:0] hrdata_r; // Read answer
   logic hresp_r; // Response answer

   logic [IW-1:0] a_idx; // Address phase index
   logic a_take; // Transfer accepted
   logic a_upper0; // Upper address bits clear
   logic a_cfg; // Hits a config word
   logic a_stat; // Hits the status word
   logic a_word; // Whole word transfer
   logic a_wr; // Accepted config write
   logic a_rd; // Accepted read
   logic fwd; // Read meets pending write
   logic [31:0] cfg_word; // Stored config word
   logic [31:0] fwd_word; // Forwarded write data
   logic [31:0] stat_word; // Status readback
   logic [31:0] rd_word; // Selected read data

   logic [W13-1:0] first_pix; // Start pixel
   logic [W13-1:0] pix_m1; // Pixels minus one
   logic [W13-1:0] first_line; // Start line
   logic [W15-1:0] lines_m1; // Lines minus one
   logic [W13-1:0] out_len; // Output line length
   logic [W13-1:0] sync_int; // Output sync interval

   logic [W13-1:0] pix_x_r; // Pixel index in line
   logic [W15-1:0] line_y_r; // Line index in frame
   logic seen_r; // A line has begun
   logic [W13-1:0] out_cnt_r; // Output pixels in line
   logic fv_r; // Formatter valid out
   logic [PIX_W-1:0] fd_r; // Formatter data out
   logic fle_r; // Output line end

   logic [W13-1:0] cur_x; // Index of this pixel
   logic [W13-1:0] x_nxt; // Next pixel index
   logic [W15-1:0] y_nxt; // Next line index
   logic seen_nxt; // Next line-seen flag
   logic [W13:0] h_off; // Pixel minus start
   logic [W15:0] v_off; // Line minus start
   logic in_h; // Pixel inside crop
   logic in_v; // Line inside crop
   logic take_pix; // Pixel fed to formatter
   logic [W13-1:0] len_m1; // Last output index
   logic len_zero; // No line length set
   logic out_last; // Pixel closes out line
   logic [W13-1:0] out_nxt; // Next output count
   logic sync_w; // Generated sync pulse

   // ****************************************************
   // Address phase decode
   // ****************************************************
   assign a_idx = haddr[sfe_pkg::SFE_IDX_LSB +: IW];
   assign a_upper0 =
      (haddr[sfe_pkg::SFE_ADDR_W-1:sfe_pkg::SFE_IDX_LSB+IW] == '0);
   assign a_take = hsel && hready &&
      htrans[sfe_pkg::SFE_HTRANS_ACT];
   assign a_word = (hsize == sfe_pkg::SFE_HSIZE_WORD);
   assign a_cfg = a_upper0 && (a_idx < IW'(NC));
   assign a_stat = a_upper0 && (a_idx == sfe_pkg::SFE_IDX_STAT);
   assign a_wr = a_take && hwrite && a_word && a_cfg;
   assign a_rd = a_take && !hwrite;

   // ****************************************************
   // Read data selection
   // ****************************************************
   // A read right after a write to the same word sees new data
   // Without it the read would return the stale word
   assign fwd = wr_pend_r && (wr_idx_r == a_idx) && a_cfg;
   assign cfg_word = a_cfg ? cfg_r[a_idx] : sfe_pkg::SFE_RST;
   assign fwd_word = a_cfg ?
      (hwdata & sfe_pkg::SFE_MASK[a_idx]) : sfe_pkg::SFE_RST;
   assign stat_word = {
      {(32-sfe_pkg::SFE_ST_LINE_LSB-W15){1'b0}},
      line_y_r,
      {(sfe_pkg::SFE_ST_LINE_LSB-2){1'b0}},
      seen_r,
      in_v};
   // Unmapped words read zero
   assign rd_word = fwd ? fwd_word :
      a_cfg ? cfg_word :
      a_stat ? stat_word : sfe_pkg::SFE_RST;

   // ****************************************************
   // Bus answer, zero wait states, always okay
   // ****************************************************
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hready_r <= 1'b1;
         hrdata_r <= sfe_pkg::SFE_RST;
      end
      else if (a_rd)
      begin
         hready_r <= 1'b1;
         hrdata_r <= rd_word;
      end
   end

   assign hreadyout = hready_r;
   assign hrdata = hrdata_r;
   assign hresp = hresp_r;

   // Response flop; every transfer is answered okay, so the
   // port comes from a register like the other outputs
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hresp_r <= sfe_pkg::SFE_HRESP_OKAY;
      else
         hresp_r <= sfe_pkg::SFE_HRESP_OKAY;
   end

   // Capture write address for its data phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_r <= 1'b0;
         wr_idx_r <= '0;
      end
      else if (hready)
      begin
         wr_pend_r <= a_wr;
         wr_idx_r <= a_idx;
      end
   end

   // ****************************************************
   // Config registers, one per word
   // ****************************************************
   genvar gi;
   generate
      for (gi = 0; gi < NC; gi++)
      begin : g_reg
         assign wr_hit[gi] = wr_pend_r && (wr_idx_r == IW'(gi));
         // Reserved bits are masked so they read zero
         // Write lands at the end of its data phase
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
               cfg_r[gi] <= sfe_pkg::SFE_RST;
            else if (wr_hit[gi])
               cfg_r[gi] <= hwdata & sfe_pkg::SFE_MASK[gi];
         end
      end
   endgenerate

   // ****************************************************
   // Field extraction
   // ****************************************************
   assign ob_window_start_h =
      cfg_r[sfe_pkg::SFE_IDX_OBH][W13-1:0];
   assign ob_window_start_v =
      cfg_r[sfe_pkg::SFE_IDX_OBV][W13-1:0];
   assign ob_window_valid_v =
      cfg_r[sfe_pkg::SFE_IDX_OBN][W13-1:0];
   assign color_convert_on =
      cfg_r[sfe_pkg::SFE_IDX_CSC][sfe_pkg::SFE_CSC_ON_BIT];
   assign first_pix = cfg_r[sfe_pkg::SFE_IDX_SPH][W13-1:0];
   assign pix_m1 = cfg_r[sfe_pkg::SFE_IDX_LNH][W13-1:0];
   assign first_line = cfg_r[sfe_pkg::SFE_IDX_SLV][W13-1:0];
   assign lines_m1 = cfg_r[sfe_pkg::SFE_IDX_LNV][W15-1:0];
   assign out_len = cfg_r[sfe_pkg::SFE_IDX_RLEN][W13-1:0];
   assign sync_int = cfg_r[sfe_pkg::SFE_IDX_HCNT][W13-1:0];

   // ****************************************************
   // Input position tracking
   // ****************************************************
   // Sync cycle restarts the pixel index at zero
   // Pixels are counted on every strobe, in window or not
   assign cur_x = horizontal_sync ? '0 : pix_x_r;
   assign x_nxt = pix_valid ? (cur_x + W13'(1)) : cur_x;
   // First sync of a frame opens line zero
   assign y_nxt = !horizontal_sync ? line_y_r :
      (seen_r ? (line_y_r + W15'(1)) : '0);
   assign seen_nxt = seen_r || horizontal_sync;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pix_x_r <= '0;
         line_y_r <= '0;
         seen_r <= 1'b0;
      end
      else if (frame_start)
      begin
         pix_x_r <= '0;
         line_y_r <= '0;
         seen_r <= 1'b0;
      end
      else
      begin
         pix_x_r <= x_nxt;
         line_y_r <= y_nxt;
         seen_r <= seen_nxt;
      end
   end

   // ****************************************************
   // Crop window
   // ****************************************************
   // Line window test uses the line index of this cycle
   // Borrow bit marks a pixel before the start position
   assign h_off = {1'b0, cur_x} - {1'b0, first_pix};
   assign in_h = !h_off[W13] && (h_off[W13-1:0] <= pix_m1);
   assign v_off = {1'b0, y_nxt} -
      {1'b0, {(W15-W13){1'b0}}, first_line};
   assign in_v = seen_nxt && !v_off[W15] &&
      (v_off[W15-1:0] <= lines_m1);
   assign take_pix = pix_valid && in_h && in_v && !frame_start;

   // ****************************************************
   // Output line length
   // ****************************************************
   // Counter runs over accepted pixels only; a zero length
   // never ends a line. Lengths above the supported maximum
   // are not refused, software keeps to the limit
   assign len_m1 = out_len - W13'(1);
   assign len_zero = (out_len == '0);
   assign out_last = !len_zero && (out_cnt_r == len_m1);
   assign out_nxt = out_last ? '0 : (out_cnt_r + W13'(1));

   // Pass accepted pixels and mark output line ends
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         fv_r <= 1'b0;
         fd_r <= '0;
         fle_r <= 1'b0;
         out_cnt_r <= '0;
      end
      else if (frame_start)
      begin
         // New frame drops any partial line
         fv_r <= 1'b0;
         fle_r <= 1'b0;
         out_cnt_r <= '0;
      end
      else if (take_pix)
      begin
         fv_r <= 1'b1;
         fd_r <= pix_data;
         fle_r <= out_last;
         out_cnt_r <= out_nxt;
      end
      else
      begin
         fv_r <= 1'b0;
         fle_r <= 1'b0;
      end
   end

   assign fmt_pix_valid = fv_r;
   assign fmt_pix_data = fd_r;
   assign fmt_line_end = fle_r;

   // ****************************************************
   // Output sync spacing
   // ****************************************************
   // Runs only while the frame is inside the line window
   // A zero interval keeps the pulse low for merged lines
   sfe_sync_gen #(
      .W(W13)
   ) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .restart(frame_start),
      .run(in_v),
      .interval(sync_int),
      .sync_pulse(sync_w)
   );

   assign fmt_out_sync = sync_w;
endmodule

// >>> src/sfe_sync_gen.sv
// Output line sync generator with programmable interval
`timescale 1ns/1ps
module sfe_sync_gen #(
   parameter int W = 13
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic restart,
   input wire logic run,
   input wire logic [W-1:0] interval,
   output logic sync_pulse
);
   // ****************************************************
   // Cycle counter
   // ****************************************************
   logic [W-1:0] cnt_r; // Cycles since last sync
   logic [W-1:0] last; // Final count of an interval
   logic at_end; // Interval complete
   logic merge; // Zero interval, no sync

   generate
      if (W < 2)
      begin : g_chk
         $error("sfe_sync_gen: W too small");
      end
   endgenerate

   assign last = interval - W'(1);
   assign merge = (interval == '0);
   assign at_end = (cnt_r == last);

   // Count cycles and pulse once per interval
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cnt_r <= '0;
         sync_pulse <= 1'b0;
      end
      else if (restart || !run || merge)
      begin
         // Idle, or lines merged with no sync
         cnt_r <= '0;
         sync_pulse <= 1'b0;
      end
      else if (at_end)
      begin
         cnt_r <= '0;
         sync_pulse <= 1'b1;
      end
      else
      begin
         cnt_r <= cnt_r + W'(1);
         sync_pulse <= 1'b0;
      end
   end
endmodule

// >>> tb/sfe_host.sv
// Host processor model issuing single bus transfers of a given size
`timescale 1ns/1ps
module sfe_host (
   input wire logic hclk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [11:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   // Bus idle at time zero
   initial
   begin
      hsel = 1'b0;
      haddr = 12'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   // One transfer; called just after a rising edge
   task automatic xfer(input logic [11:0] a, input logic w,
      input logic [2:0] s, input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= s;
      @(posedge hclk);
      while (hready !== 1'b1)
         @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1)
         @(posedge hclk);
      q = hrdata;
   endtask
endmodule

// >>> tb/sfe_regs_sva.sv
// Port level checks for the front end config bank
`timescale 1ns/1ps
module sfe_regs_sva #(
   parameter int PIX_W = 12
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [sfe_pkg::SFE_ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic pix_valid,
   input wire logic [PIX_W-1:0] pix_data,
   input wire logic fmt_pix_valid,
   input wire logic [PIX_W-1:0] fmt_pix_data,
   input wire logic fmt_line_end,
   input wire logic fmt_out_sync,
   input wire logic [sfe_pkg::SFE_W13-1:0] ob_window_start_h,
   input wire logic [sfe_pkg::SFE_W13-1:0] ob_window_start_v,
   input wire logic [sfe_pkg::SFE_W13-1:0] ob_window_valid_v,
   input wire logic color_convert_on
);
   // ****************************************
   // Write tracking
   // ****************************************
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic wr_q; // Word write in data phase
   logic [3:0] idx_q; // Its word index
   logic [12:0] hcnt_q; // Shadow of sync interval
   wire logic wr_w = hsel && hready && htrans[1] && hwrite
      && hsize == 3'h2 && haddr[11:6] == 6'h0;
   wire logic hcnt_w = wr_q && idx_q == 4'h8;
   // Captures address phase and interval writes
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_q <= 1'b0;
         idx_q <= 4'h0;
         hcnt_q <= 13'h0;
      end
      else
      begin
         wr_q <= wr_w;
         idx_q <= haddr[5:2];
         hcnt_q <= hcnt_w ? hwdata[12:0] : hcnt_q;
      end
   end
   // ****************************************
   // Assertions
   // ****************************************
   a_obh_write: assert property (wr_q && idx_q == 4'h0 |=>
      ob_window_start_h == $past(hwdata[12:0])) else $error("ob h");
   a_obv_write: assert property (wr_q && idx_q == 4'h1 |=>
      ob_window_start_v == $past(hwdata[12:0])) else $error("ob v");
   a_obn_write: assert property (wr_q && idx_q == 4'h2 |=>
      ob_window_valid_v == $past(hwdata[12:0])) else $error("ob n");
   a_csc_follow: assert property (wr_q && idx_q == 4'h9 |=>
      color_convert_on == $past(hwdata[0])) else $error("csc set");
   a_csc_hold: assert property (!(wr_q && idx_q == 4'h9) |=>
      $stable(color_convert_on)) else $error("csc moved");
   a_pix_delay: assert property (fmt_pix_valid |-> $past(pix_valid)
      && fmt_pix_data == $past(pix_data)) else $error("pixel path");
   a_end_with_pix: assert property (fmt_line_end |->
      fmt_pix_valid) else $error("line end alone");
   a_sync_gap: assert property (fmt_out_sync && hcnt_q == 13'h3
      |=> !fmt_out_sync [*2]) else $error("sync gap");
   a_sync_off: assert property (hcnt_q == 13'h0
      && $past(hcnt_q) == 13'h0 |-> !fmt_out_sync) else $error("sync");
   a_rst_zero: assert property ($rose(hresetn) |->
      !color_convert_on && ob_window_start_h == 13'h0) else $error("rst");
   c_pix: cover property (fmt_pix_valid);
   c_end: cover property (fmt_line_end);
   c_sync: cover property (fmt_out_sync);
endmodule
bind sfe_regs sfe_regs_sva #(.PIX_W(PIX_W)) u_sfe_regs_sva (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .pix_valid(pix_valid), .pix_data(pix_data),
   .fmt_pix_valid(fmt_pix_valid), .fmt_pix_data(fmt_pix_data),
   .fmt_line_end(fmt_line_end), .fmt_out_sync(fmt_out_sync),
   .ob_window_start_h(ob_window_start_h),
   .ob_window_start_v(ob_window_start_v),
   .ob_window_valid_v(ob_window_valid_v),
   .color_convert_on(color_convert_on));

// >>> tb/sfe_regs_tb.sv
// Self-checking bench for the front end config bank
`timescale 1ns/1ps
module sfe_regs_tb;
   logic hclk = 1'b0; // Bus clock
   logic hresetn = 1'b0; // Active low reset
   logic pix_valid = 1'b0; // Sensor pixel strobe
   logic [11:0] pix_data = 12'h0; // Sensor pixel value
   logic horizontal_sync = 1'b0; // Line start pulse
   logic frame_start = 1'b0; // Frame start pulse
   wire logic hsel, hwrite, hrdy, hresp, fmt_pix_valid, fmt_line_end;
   wire logic fmt_out_sync, color_convert_on;
   wire logic [11:0] haddr, fmt_pix_data;
   wire logic [1:0] htrans;
   wire logic [2:0] hsize;
   wire logic [31:0] hwdata, hrdata;
   wire logic [12:0] obh, obv, obn;
   int error_cnt = 0;
   int tests_run = 0;
   int cyc = 0, last = -1, acc = 0, ends = 0, syncs = 0;
   int fx, nx, fy, ny, gap; // Expected window and sync spacing
   logic [31:0] q, d;
   always #12.5 hclk = ~hclk;
   sfe_host u_sfe_host (.hclk(hclk), .hready(hrdy), .hrdata(hrdata),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata));
   sfe_regs u_sfe_regs (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hresp(hresp),
      .hrdata(hrdata), .pix_valid(pix_valid), .pix_data(pix_data),
      .horizontal_sync(horizontal_sync), .frame_start(frame_start),
      .fmt_pix_valid(fmt_pix_valid), .fmt_pix_data(fmt_pix_data),
      .fmt_line_end(fmt_line_end), .fmt_out_sync(fmt_out_sync),
      .ob_window_start_h(obh), .ob_window_start_v(obv),
      .ob_window_valid_v(obn), .color_convert_on(color_convert_on));
   // ****************************************
   // Helpers
   // ****************************************
   task automatic chk(input logic [31:0] g, e, input string m);
      tests_run++;
      if (g !== e)
      begin
         $display("[ERR] %0t %s", $time, m);
         error_cnt++;
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      u_sfe_host.xfer(a, 1'b1, 3'h2, v, q);
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      u_sfe_host.xfer(a, 1'b0, 3'h2, 32'h0, q);
      chk(q, e, "read value");
      chk(32'(hresp), 32'h0, "bus answer");
   endtask
   // Formatter setup, words 3 to 8
   task automatic cfg(input int v[6]);
      for (int i = 0; i < 6; i++)
         wr(12'((i + 3) * 4), 32'(v[i]));
   endtask
   // Frame of nl lines, 8 pixels each with idle tail
   task automatic frame(input int nl);
      last = -1;
      acc = 0;
      ends = 0;
      syncs = 0;
      frame_start <= 1'b1;
      @(posedge hclk) frame_start <= 1'b0;
      for (int y = 0; y < nl; y++)
         for (int c = 0; c < 12; c++)
         begin
            @(posedge hclk);
            horizontal_sync <= (c == 0);
            pix_valid <= (c < 8);
            pix_data <= 12'(y * 16 + c);
         end
      repeat (6) @(posedge hclk);
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Output monitor, sampled away from the launching edge
   always @(negedge hclk)
   begin
      cyc++;
      if (fmt_pix_valid === 1'b1)
      begin
         acc++;
         chk(32'(fmt_pix_data[3:0] >= fx && fmt_pix_data[3:0] < fx + nx
            && fmt_pix_data[7:4] >= fy && fmt_pix_data[7:4] < fy + ny),
            32'h1, "pixel outside window");
      end
      if (fmt_line_end === 1'b1)
         ends++;
      if (fmt_out_sync === 1'b1)
      begin
         if (last >= 0)
            chk(32'(cyc - last), 32'(gap), "sync spacing");
         last = cyc;
         syncs++;
      end
   end
   // Hang guard
   initial
   begin
      #500us;
      $display("[ERR] %0t watchdog expired", $time);
      error_cnt++;
      print_verdict;
   end
   // ****************************************
   // Test sequence
   // ****************************************
   initial
   begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int i = 0; i < 10; i++)
      begin
         d = 32'hfeed_a5c2 ^ 32'(i); // Reserved bits set deliberately
         rc(12'(i * 4), 32'h0);
         wr(12'(i * 4), d);
         rc(12'(i * 4), d & sfe_pkg::SFE_MASK[i]);
      end
      chk(32'(obh), 32'h05c2, "ob h port");
      chk(32'(obv), 32'h05c3, "ob v port");
      chk(32'(obn), 32'h05c0, "ob n port");
      chk(32'(color_convert_on), 32'h1, "converter on");
      wr(12'h024, 32'h0);
      @(posedge hclk);
      chk(32'(color_convert_on), 32'h0, "converter off");
      wr(12'h028, 32'hffff_ffff);
      rc(12'h028, 32'h0);
      wr(12'h02c, 32'hffff_ffff);
      rc(12'h02c, 32'h0);
      wr(12'h040, 32'h0000_1fff);
      rc(12'h000, 32'h0000_05c2);
      u_sfe_host.xfer(12'h004, 1'b1, 3'h1, 32'h0, q);
      rc(12'h004, 32'h0000_05c3);
      $display("register test done");
      fx = 2; nx = 4; fy = 1; ny = 2; gap = 3;
      cfg('{2, 3, 1, 1, 4, 3});
      frame(4);
      chk(32'(acc), 32'd8, "pixel count");
      chk(32'(ends), 32'd2, "line ends");
      chk(32'(syncs > 0), 32'h1, "sync seen");
      rc(12'h028, 32'h0003_0002);
      $display("window frame done");
      fx = 0; nx = 1; fy = 0; ny = 1;
      cfg('{0, 0, 0, 0, 1, 0});
      frame(2);
      chk(32'(acc), 32'd1, "single pixel");
      chk(32'(ends), 32'd1, "single end");
      chk(32'(syncs), 32'd0, "no sync");
      $display("minimal frame done");
      print_verdict;
   end
endmodule
